// *** verif/scpi_status_reporting_bench.sv ***
// bench for the status reporting block
module scpi_status_reporting_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, srst = 1, eq = 0, msg = 0;
    logic        wr = 0, rd = 0, rd_d = 0;
    logic [15:0] oper = 0, ques = 0, wdata = 0;
    logic [7:0]  evp = 0;
    logic [3:0]  sel = 0;
    wire  [15:0] rdata;
    wire         srq;
    wire  [7:0]  sbyte;
    int          srq_cnt, error_cnt = 0, checks_done = 0, seed = 45447;
    logic [15:0] exp_q[$];
    always #5 clk = ~clk;
    ssr_status_reporting i_dut (.clk(clk), .srst(srst),
        .oper_status_in(oper), .ques_status_in(ques),
        .std_event_pulse(evp), .error_queue_nonempty(eq),
        .output_message_ready(msg), .reg_wr(wr), .reg_rd(rd),
        .reg_sel(sel), .reg_wdata(wdata), .reg_rdata_ff(rdata),
        .service_request_ff(srq), .status_summary_byte_ff(sbyte));
    ssr_host_model i_host (.clk(clk), .service_request_ff(srq),
        .srq_cnt(srq_cnt));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // result monitor: a read answer lands one edge after the strobe
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d === 1'b1) chk(rdata, exp_q.pop_front());
    task automatic wr_reg(input logic [3:0] s, input logic [15:0] d);
        @(posedge clk);
        sel <= s; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] s, input logic [15:0] e);
        @(posedge clk);
        sel <= s; rd <= 1'b1; exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // input sync plus event and byte stages, with margin
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask
    task automatic set_in(input logic [3:0] base, input logic [15:0] v);
        if (base == 4'h4) oper <= v;
        else ques <= v;
    endtask
    task automatic run_reg(input logic [3:0] base, input int b);
        logic [15:0] v;
        int c;
        v = 16'($random(seed));
        wr_reg(base, 16'hFFFF);
        set_in(base, 16'h8003);
        settle;
        rd_reg(base, 16'h0003);
        rd_reg(base, 16'h0003);
        rd_reg(base + 4, 16'h0003);
        rd_reg(base + 4, 16'h0000);
        wr_reg(base + 1, v);
        rd_reg(base + 1, v & 16'h7FFF);
        rd_reg(base + 1, v & 16'h7FFF);
        wr_reg(base + 1, 16'h0001);
        wr_reg(base + 2, 16'h0002);
        set_in(base, 16'h0000);
        settle;
        rd_reg(base + 4, 16'h0002);
        wr_reg(base + 3, 16'h0001);
        rd_reg(base + 3, 16'h0001);
        wr_reg(4'h1, 16'h0001 << b);
        rd_reg(4'h1, 16'h0001 << b);
        c = srq_cnt;
        set_in(base, 16'h0001);
        settle;
        rd_reg(4'h0, (16'h0001 << b) | 16'h0040);
        chk(16'(srq_cnt - c), 16'h0001);
        rd_reg(base + 4, 16'h0001);
        wr_reg(base + 1, 16'h0002);
        set_in(base, 16'h0003);
        @(posedge clk);
        rd_reg(base + 4, 16'h0000);
        rd_reg(base + 4, 16'h0002);
        settle;
        rd_reg(4'h0, 16'h0000);
        $display("register test at base %0d done", base);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        int c;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        run_reg(4'h4, 7);
        run_reg(4'h9, 3);
        wr_reg(4'h1, 16'h0040);
        eq <= 1'b1;
        settle;
        rd_reg(4'h0, 16'h0004);
        wr_reg(4'h1, 16'h0034);
        wr_reg(4'h3, 16'h0020);
        eq <= 1'b0;
        settle;
        c = srq_cnt;
        eq <= 1'b1;
        settle;
        chk(16'(srq_cnt - c), 16'h0001);
        msg <= 1'b1;
        evp <= 8'h20;
        @(posedge clk);
        evp <= 8'h00;
        settle;
        rd_reg(4'h0, 16'h0074);
        rd_reg(4'h2, 16'h0020);
        rd_reg(4'h2, 16'h0000);
        $display("summary byte test done");
        test_done;
    end
    initial begin
        #200000;
        error_cnt++;
        test_done;
    end
endmodule // scpi_status_reporting_bench
bind ssr_status_reporting ssr_status_sva i_sva (.clk(clk), .srst(srst),
    .oper_status_in(oper_status_in), .reg_sel(reg_sel),
    .error_queue_nonempty(error_queue_nonempty),
    .output_message_ready(output_message_ready),
    .reg_rdata_ff(reg_rdata_ff), .service_request_ff(service_request_ff),
    .status_summary_byte_ff(status_summary_byte_ff));

// *** verif/ssr_host_model.sv ***
// controller side model: counts service request pulses
module ssr_host_model (
    input  wire clk,
    input  wire service_request_ff,
    output int  srq_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    initial srq_cnt = 0;
    always @(posedge clk) begin
        if (service_request_ff === 1'b1) srq_cnt <= srq_cnt + 1;
    end
endmodule // ssr_host_model

// *** verif/ssr_status_sva.sv ***
// port assertions of the status reporting block
module ssr_status_sva (
    input wire        clk,
    input wire        srst,
    input wire [15:0] oper_status_in,
    input wire        error_queue_nonempty,
    input wire        output_message_ready,
    input wire [3:0]  reg_sel,
    input wire [15:0] reg_rdata_ff,
    input wire        service_request_ff,
    input wire [7:0]  status_summary_byte_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_unused;
        status_summary_byte_ff[1:0] == 2'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused byte bits set");
    property p_mss;
        status_summary_byte_ff[6] |->
            |{status_summary_byte_ff[7], status_summary_byte_ff[5:2]};
    endproperty
    a_mss: assert property (p_mss)
        else $error("master summary without cause");
    property p_srq;
        service_request_ff |-> |(status_summary_byte_ff
            & ~$past(status_summary_byte_ff) & 8'hBF);
    endproperty
    a_srq: assert property (p_srq)
        else $error("service request without rising bit");
    property p_err_on;
        error_queue_nonempty [*6] |-> status_summary_byte_ff[2];
    endproperty
    a_err_on: assert property (p_err_on)
        else $error("error bit missing");
    property p_err_off;
        !error_queue_nonempty [*6] |-> !status_summary_byte_ff[2];
    endproperty
    a_err_off: assert property (p_err_off)
        else $error("error bit stuck");
    property p_mav;
        output_message_ready [*6] |-> status_summary_byte_ff[4];
    endproperty
    a_mav: assert property (p_mav)
        else $error("message bit missing");
    property p_top_zero;
        reg_rdata_ff[15] == 1'b0;
    endproperty
    a_top_zero: assert property (p_top_zero)
        else $error("read bit 15 set");
    property p_cond;
        ($stable(oper_status_in) [*5] ##0 $past(reg_sel) == 4'h4)
            |-> reg_rdata_ff == {1'b0, oper_status_in[14:0]};
    endproperty
    a_cond: assert property (p_cond)
        else $error("condition read differs from inputs");
endmodule // ssr_status_sva

// *** verilog/ssr_map.vh ***
// register selectors, field positions and widths of the status reporting block
`ifndef SSR_MAP_VH
`define SSR_MAP_VH
`define SSR_REG_W        16
`define SSR_BYTE_W       8
`define SSR_SEL_W        4
// register selectors on the access port
`define SSR_SEL_SBY      4'h0
`define SSR_SEL_RQM      4'h1
`define SSR_SEL_SEV      4'h2
`define SSR_SEL_SEM      4'h3
`define SSR_SEL_OPC      4'h4
`define SSR_SEL_OPP      4'h5
`define SSR_SEL_OPN      4'h6
`define SSR_SEL_OPE      4'h7
`define SSR_SEL_OPV      4'h8
`define SSR_SEL_QUC      4'h9
`define SSR_SEL_QUP      4'hA
`define SSR_SEL_QUN      4'hB
`define SSR_SEL_QUE      4'hC
`define SSR_SEL_QUV      4'hD
// status byte bit positions
`define SSR_BIT_ERR      2
`define SSR_BIT_QUES     3
`define SSR_BIT_MSG      4
`define SSR_BIT_SES      5
`define SSR_BIT_MST      6
`define SSR_BIT_OPER     7
// bit 15 of every 16-bit part forced to zero
`define SSR_PART_MASK    16'h7FFF
`define SSR_ZERO16       16'h0000
`define SSR_ZERO8        8'h00
`define SSR_RQ_KEEP      8'hBF
`endif

// *** verilog/ssr_status_reporting.v ***
// hierarchical status reporting: operation, questionable, event, status byte
`include "ssr_map.vh"
module ssr_status_reporting #(
    parameter REG_W  = `SSR_REG_W,
    parameter BYTE_W = `SSR_BYTE_W,
    parameter SEL_W  = `SSR_SEL_W
) (
    input  wire                   clk,
    input  wire                   srst,
    input  wire [REG_W-1:0]       oper_status_in,
    input  wire [REG_W-1:0]       ques_status_in,
    input  wire [BYTE_W-1:0]      std_event_pulse,
    input  wire                   error_queue_nonempty,
    input  wire                   output_message_ready,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    input  wire [SEL_W-1:0]       reg_sel,
    input  wire [REG_W-1:0]       reg_wdata,
    output reg  [REG_W-1:0]       reg_rdata_ff,
    output reg                    service_request_ff,
    output reg  [BYTE_W-1:0]      status_summary_byte_ff
);

    // external status arrives asynchronously: two-flop synchronisers
    reg  [REG_W-1:0]  oper_s1_ff;
    reg  [REG_W-1:0]  oper_s2_ff;
    reg  [REG_W-1:0]  ques_s1_ff;
    reg  [REG_W-1:0]  ques_s2_ff;
    reg               err_s1_ff;
    reg               err_s2_ff;
    reg               msg_s1_ff;
    reg               msg_s2_ff;

    // previous condition values for edge detection
    reg  [REG_W-1:0]  oper_cond_ff;
    reg  [REG_W-1:0]  ques_cond_ff;

    reg  [REG_W-1:0]  oper_rise_ff;
    reg  [REG_W-1:0]  oper_fall_ff;
    reg  [REG_W-1:0]  oper_event_ff;
    reg  [REG_W-1:0]  oper_enable_ff;
    reg  [REG_W-1:0]  ques_rise_ff;
    reg  [REG_W-1:0]  ques_fall_ff;
    reg  [REG_W-1:0]  ques_event_ff;
    reg  [REG_W-1:0]  ques_enable_ff;
    reg  [BYTE_W-1:0] std_event_ff;
    reg  [BYTE_W-1:0] std_mask_ff;
    reg  [BYTE_W-1:0] srq_mask_ff;
    reg  [BYTE_W-1:0] sbyte_prev_ff;

    // next values
    reg  [REG_W-1:0]  nxt_oper_event;
    reg  [REG_W-1:0]  nxt_ques_event;
    reg  [BYTE_W-1:0] nxt_std_event;
    reg  [BYTE_W-1:0] nxt_sbyte;
    reg  [REG_W-1:0]  nxt_rdata;

    // summary and edge helpers
    wire [REG_W-1:0]  oper_cond;
    wire [REG_W-1:0]  ques_cond;
    wire              oper_sum;
    wire              ques_sum;
    wire              std_sum;
    wire [BYTE_W-1:0] sbyte_rise;

    // filtered transitions of one 16-bit register
    function [15:0] edge_hits;
        input [15:0] cur;
        input [15:0] prev;
        input [15:0] rise;
        input [15:0] fall;
        begin
            edge_hits = ((cur & ~prev & rise) | (~cur & prev & fall))
                        & `SSR_PART_MASK;
        end
    endfunction

    function read_of;
        input [3:0] sel;
        input [3:0] target;
        begin
            read_of = reg_rd && (sel == target);
        end
    endfunction

    function wr_of;
        input [3:0] sel;
        input [3:0] target;
        begin
            wr_of = reg_wr && (sel == target);
        end
    endfunction

    // status pins except std_event_pulse pass two flops before any logic reads them
    always @(posedge clk) begin
        if (srst) begin
            oper_s1_ff <= `SSR_ZERO16;
            oper_s2_ff <= `SSR_ZERO16;
        end else begin
            oper_s1_ff <= oper_status_in;
            oper_s2_ff <= oper_s1_ff;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            ques_s1_ff <= `SSR_ZERO16;
            ques_s2_ff <= `SSR_ZERO16;
        end else begin
            ques_s1_ff <= ques_status_in;
            ques_s2_ff <= ques_s1_ff;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            err_s1_ff <= 1'b0;
            err_s2_ff <= 1'b0;
        end else begin
            err_s1_ff <= error_queue_nonempty;
            err_s2_ff <= err_s1_ff;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            msg_s1_ff <= 1'b0;
            msg_s2_ff <= 1'b0;
        end else begin
            msg_s1_ff <= output_message_ready;
            msg_s2_ff <= msg_s1_ff;
        end
    end

    // condition parts are never stored from the bus, only followed
    assign oper_cond = oper_s2_ff & `SSR_PART_MASK;
    assign ques_cond = ques_s2_ff & `SSR_PART_MASK;

    assign oper_sum = |(oper_event_ff & oper_enable_ff);
    assign ques_sum = |(ques_event_ff & ques_enable_ff);
    assign std_sum  = |(std_event_ff & std_mask_ff);

    // each event part: clear on read first, then or in the new
    // filtered edges or event pulses, so a transition in the read cycle survives
    always @* begin
        nxt_oper_event = oper_event_ff;
        if (read_of(reg_sel, `SSR_SEL_OPV))
            nxt_oper_event = `SSR_ZERO16;
        nxt_oper_event = nxt_oper_event | edge_hits(oper_cond, oper_cond_ff,
            oper_rise_ff, oper_fall_ff);
    end

    always @* begin
        nxt_ques_event = ques_event_ff;
        if (read_of(reg_sel, `SSR_SEL_QUV))
            nxt_ques_event = `SSR_ZERO16;
        nxt_ques_event = nxt_ques_event | edge_hits(ques_cond, ques_cond_ff,
            ques_rise_ff, ques_fall_ff);
    end

    always @* begin
        nxt_std_event = std_event_ff;
        if (read_of(reg_sel, `SSR_SEL_SEV))
            nxt_std_event = `SSR_ZERO8;
        nxt_std_event = nxt_std_event | std_event_pulse;
    end

    // summaries recomputed each cycle, never stored on their own
    always @* begin
        nxt_sbyte = `SSR_ZERO8;
        nxt_sbyte[`SSR_BIT_ERR]  = err_s2_ff;
        nxt_sbyte[`SSR_BIT_QUES] = ques_sum;
        nxt_sbyte[`SSR_BIT_MSG]  = msg_s2_ff;
        nxt_sbyte[`SSR_BIT_SES]  = std_sum;
        nxt_sbyte[`SSR_BIT_OPER] = oper_sum;
        nxt_sbyte[`SSR_BIT_MST]  =
            |(nxt_sbyte & srq_mask_ff & `SSR_RQ_KEEP);
    end

    // bits that go 0->1 this cycle; bit 6 never requests service
    assign sbyte_rise = nxt_sbyte & ~sbyte_prev_ff & `SSR_RQ_KEEP;

    // unmapped selectors read zero; condition parts are never written
    always @* begin
        case (reg_sel)
            `SSR_SEL_SBY: nxt_rdata = {`SSR_ZERO8, status_summary_byte_ff};
            `SSR_SEL_RQM: nxt_rdata = {`SSR_ZERO8, srq_mask_ff};
            `SSR_SEL_SEV: nxt_rdata = {`SSR_ZERO8, std_event_ff};
            `SSR_SEL_SEM: nxt_rdata = {`SSR_ZERO8, std_mask_ff};
            `SSR_SEL_OPC: nxt_rdata = oper_cond;
            `SSR_SEL_OPP: nxt_rdata = oper_rise_ff;
            `SSR_SEL_OPN: nxt_rdata = oper_fall_ff;
            `SSR_SEL_OPE: nxt_rdata = oper_enable_ff;
            `SSR_SEL_OPV: nxt_rdata = oper_event_ff;
            `SSR_SEL_QUC: nxt_rdata = ques_cond;
            `SSR_SEL_QUP: nxt_rdata = ques_rise_ff;
            `SSR_SEL_QUN: nxt_rdata = ques_fall_ff;
            `SSR_SEL_QUE: nxt_rdata = ques_enable_ff;
            `SSR_SEL_QUV: nxt_rdata = ques_event_ff;
            default:      nxt_rdata = `SSR_ZERO16;
        endcase
    end

    // condition history feeds the edge detectors
    always @(posedge clk) begin
        if (srst) begin
            oper_cond_ff  <= `SSR_ZERO16;
            oper_event_ff <= `SSR_ZERO16;
        end else begin
            oper_cond_ff  <= oper_cond;
            oper_event_ff <= nxt_oper_event;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            ques_cond_ff  <= `SSR_ZERO16;
            ques_event_ff <= `SSR_ZERO16;
        end else begin
            ques_cond_ff  <= ques_cond;
            ques_event_ff <= nxt_ques_event;
        end
    end

    always @(posedge clk) begin
        if (srst)
            std_event_ff <= `SSR_ZERO8;
        else
            std_event_ff <= nxt_std_event;
    end

    // rising filters start open so every 0->1 edge is caught
    always @(posedge clk) begin
        if (srst)
            oper_rise_ff <= `SSR_PART_MASK;
        else if (wr_of(reg_sel, `SSR_SEL_OPP))
            oper_rise_ff <= reg_wdata & `SSR_PART_MASK;
    end

    always @(posedge clk) begin
        if (srst)
            ques_rise_ff <= `SSR_PART_MASK;
        else if (wr_of(reg_sel, `SSR_SEL_QUP))
            ques_rise_ff <= reg_wdata & `SSR_PART_MASK;
    end

    // falling filters start closed
    always @(posedge clk) begin
        if (srst)
            oper_fall_ff <= `SSR_ZERO16;
        else if (wr_of(reg_sel, `SSR_SEL_OPN))
            oper_fall_ff <= reg_wdata & `SSR_PART_MASK;
    end

    always @(posedge clk) begin
        if (srst)
            ques_fall_ff <= `SSR_ZERO16;
        else if (wr_of(reg_sel, `SSR_SEL_QUN))
            ques_fall_ff <= reg_wdata & `SSR_PART_MASK;
    end

    // enables start closed: no summary until software opts in
    always @(posedge clk) begin
        if (srst)
            oper_enable_ff <= `SSR_ZERO16;
        else if (wr_of(reg_sel, `SSR_SEL_OPE))
            oper_enable_ff <= reg_wdata & `SSR_PART_MASK;
    end

    always @(posedge clk) begin
        if (srst)
            ques_enable_ff <= `SSR_ZERO16;
        else if (wr_of(reg_sel, `SSR_SEL_QUE))
            ques_enable_ff <= reg_wdata & `SSR_PART_MASK;
    end

    // 8-bit masks take the low byte of the write data
    always @(posedge clk) begin
        if (srst)
            std_mask_ff <= `SSR_ZERO8;
        else if (wr_of(reg_sel, `SSR_SEL_SEM))
            std_mask_ff <= reg_wdata[BYTE_W-1:0];
    end

    always @(posedge clk) begin
        if (srst)
            srq_mask_ff <= `SSR_ZERO8;
        else if (wr_of(reg_sel, `SSR_SEL_RQM))
            srq_mask_ff <= reg_wdata[BYTE_W-1:0];
    end

    // previous byte kept for service request edge detection
    always @(posedge clk) begin
        if (srst) begin
            status_summary_byte_ff <= `SSR_ZERO8;
            sbyte_prev_ff          <= `SSR_ZERO8;
        end else begin
            status_summary_byte_ff <= nxt_sbyte;
            sbyte_prev_ff          <= nxt_sbyte;
        end
    end

    // one-cycle pulse in each cycle with an enabled 0->1 status byte edge
    always @(posedge clk) begin
        if (srst)
            service_request_ff <= 1'b0;
        else
            service_request_ff <= |(sbyte_rise & srq_mask_ff);
    end

    // read answer holds the contents from before any read clear
    always @(posedge clk) begin
        if (srst)
            reg_rdata_ff <= `SSR_ZERO16;
        else
            reg_rdata_ff <= nxt_rdata;
    end

endmodule // ssr_status_reporting
